/* File: ebi_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// 16-bit memory on the far side of the bus
// ----------------------------------------
module ebi_mem_model (
	input wire logic clk_i,
	input wire logic sep_i,
	input wire ebi_pkg::ebi_pins_t pins_i,
	output logic [15:0] lines_o
);
	logic [7:0] mem [0:255];
	logic [7:0] adr = 8'h00;
	logic [7:0] ea;
	logic [15:0] junk = 16'hA5C3;
	// separate mode has own address lines, multiplexed needs the latched copy
	assign ea = sep_i ? pins_i.lower_address_lines[7:0] : adr;
	// a released bus shows a moving pattern, never the last word
	assign lines_o = pins_i.read_strobe_n ? junk : {mem[{ea[7:1], 1'b1}], mem[{ea[7:1], 1'b0}]};
	// latch the address, store each lane whose strobe is low
	always @(posedge clk_i) begin
		junk <= ~junk;
		if (pins_i.address_latch_strobe)
			adr <= pins_i.shared_addr_data_lines[7:0];
		if (!pins_i.byte_write_strobes_n[0])
			mem[{ea[7:1], 1'b0}] <= pins_i.shared_addr_data_lines[7:0];
		if (!pins_i.byte_write_strobes_n[1])
			mem[{ea[7:1], 1'b1}] <= pins_i.shared_addr_data_lines[15:8];
	end
endmodule

/* File: ebi_piece.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// one bus cycle of a possibly misaligned access
// ------------------------------------------------------------
module ebi_piece (
	input wire logic a0_i,
	input wire logic [2:0] rem_i,
	input wire logic [1:0] boff_i,
	input wire logic wide_i,
	input wire logic [31:0] wdata_i,
	output logic two_o,
	output logic hi_o,
	output logic [15:0] data_o,
	output logic [1:0] wr_mask_o
);
	logic [7:0] b0;
	logic [7:0] b1;

	// pick the bytes of this piece, lower address first
	always_comb begin
		b0 = wdata_i[{boff_i, 3'h0} +: 8];
		b1 = wdata_i[{boff_i + 2'h1, 3'h0} +: 8];
	end

	// a halfword only when the bus is wide, the address even
	// and two bytes remain
	always_comb begin
		two_o = wide_i && !a0_i && (rem_i >= 3'h2);
		hi_o = wide_i && a0_i;
		if (two_o) begin
			data_o = {b1, b0};
			wr_mask_o = 2'b11;
		end else begin
			data_o = {b0, b0};
			wr_mask_o = hi_o ? 2'b10 : 2'b01;
		end
	end

endmodule

/* File: ebi_pkg.sv */
package ebi_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] REG_MODE_OFS = 4'h0;
	localparam logic [3:0] REG_WIDTH_OFS = 4'h2;
	localparam logic [3:0] REG_STATUS_OFS = 4'h4;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] WIDTH_RST = 16'h5555;
	localparam int MODE_SEP_BIT = 0;

	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam logic [23:0] INT_ROM_TOP = 24'h0FFFFF;
	localparam int AREA_MSB = 23;
	localparam int AREA_LSB = 21;

	// ------------------------------------------------------------
	// timing, in basic clocks (one output clock period)
	// ------------------------------------------------------------
	localparam int CLK_PER_BASIC = 2;
	localparam logic [1:0] ROM_SEQ_CLK = 2'h1;
	localparam logic [1:0] ROM_BRANCH_CLK = 2'h2;
	localparam logic [1:0] ROM_OPERAND_CLK = 2'h3;
	localparam logic [1:0] RAM_SEQ_CLK = 2'h1;
	localparam logic [1:0] RAM_BRANCH_CLK = 2'h2;
	localparam logic [1:0] RAM_OPERAND_CLK = 2'h1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SZ_BYTE,
		SZ_HALF,
		SZ_WORD
	} ebi_size_t;

	typedef enum logic [1:0] {
		SP_EXT,
		SP_ROM,
		SP_RAM,
		SP_PERIPH
	} ebi_space_t;

	typedef enum logic [1:0] {
		AK_FETCH_SEQ,
		AK_FETCH_BRANCH,
		AK_OPERAND
	} ebi_kind_t;

	typedef struct packed {
		logic [23:0] addr;
		ebi_size_t size;
		logic write;
		logic [31:0] wdata;
		ebi_space_t space;
		ebi_kind_t kind;
		logic conflict;
	} ebi_req_t;

	typedef struct packed {
		logic [15:0] shared_addr_data_lines;
		logic shared_oe;
		logic [7:0] upper_address_lines;
		logic [15:0] lower_address_lines;
		logic address_latch_strobe;
		logic read_strobe_n;
		logic [1:0] byte_write_strobes_n;
		logic [3:0] chip_select_lines_n;
	} ebi_pins_t;

endpackage

/* File: ebi_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker of the bus interface
// ----------------------------------------
module ebi_props (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic cpu_valid_i,
	input wire ebi_pkg::ebi_req_t cpu_req_i,
	input wire logic cpu_ready_o,
	input wire logic cpu_done_o,
	input wire ebi_pkg::ebi_pins_t pins_o,
	input wire logic bus_hold_acknowledge_n_o
);
	logic sep;
	logic idle;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// no select low means the bus is quiet
	assign idle = pins_o.chip_select_lines_n == 4'hF;
	// shadow of the mode bit: the pins alone cannot tell the modes apart
	always_ff @(posedge clk_i)
		if (srst_i)
			sep <= 1'b0;
		else if (reg_wr_i && reg_addr_i == ebi_pkg::REG_MODE_OFS)
			sep <= reg_wdata_i[ebi_pkg::MODE_SEP_BIT];
	a_mode_upper_zero: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == ebi_pkg::REG_MODE_OFS
		|-> reg_rdata_o[15:1] == 15'h0000)
		else $error("mode register upper bits not zero");
	a_sep_no_latch: assert property (sep |-> !pins_o.address_latch_strobe)
		else $error("latch strobe in separate mode");
	a_latch_with_addr: assert property (
		$rose(pins_o.address_latch_strobe) |-> !sep && pins_o.shared_oe && !idle)
		else $error("latch strobe outside an address phase");
	a_area_low: assert property (
		!pins_o.chip_select_lines_n[0] |-> pins_o.upper_address_lines[7:5] == 3'h0)
		else $error("first select outside the lowest area");
	a_mux_min_len: assert property (
		$fell(&pins_o.chip_select_lines_n) && !sep |-> !idle [*6])
		else $error("multiplexed cycle too short");
	a_sep_min_len: assert property (
		$fell(&pins_o.chip_select_lines_n) && sep |-> !idle [*4])
		else $error("separate cycle too short");
	a_ram_quiet: assert property (
		cpu_valid_i && cpu_ready_o && cpu_req_i.space == ebi_pkg::SP_RAM
		&& cpu_req_i.kind == ebi_pkg::AK_OPERAND
		|-> ##1 (idle && pins_o.read_strobe_n && !cpu_done_o) [*2] ##1 cpu_done_o)
		else $error("internal operand access wrong");
	a_hold_floats: assert property (
		!bus_hold_acknowledge_n_o |-> idle && !pins_o.shared_oe)
		else $error("bus driven while handed away");
endmodule

/* File: ebi_top.sv */
`timescale 1ns/1ps
module ebi_top (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic cpu_valid_i,
	input wire ebi_pkg::ebi_req_t cpu_req_i,
	output logic cpu_ready_o,
	output logic cpu_done_o,
	output logic [31:0] cpu_rdata_o,
	input wire logic [15:0] shared_addr_data_lines_i,
	input wire logic ext_wait_n_i,
	input wire logic bus_hold_request_n_i,
	output ebi_pkg::ebi_pins_t pins_o,
	output logic system_clock_output_o,
	output logic bus_hold_acknowledge_n_o
);

	// ------------------------------------------------------------
	// types and state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_TW,
		ST_LAST,
		ST_INT,
		ST_HOLD
	} ebi_state_t;

	ebi_state_t state;
	ebi_pkg::ebi_req_t cur;
	logic ph;
	logic sep_mode;
	logic [15:0] width_cfg;
	logic [1:0] boff;
	logic [2:0] rem;
	logic [1:0] lat;
	logic [31:0] rbuf;
	logic int_rom;
	logic periph;

	// synchronisers, first stages read only by second stages
	logic [15:0] din_s1;
	logic [15:0] din_s2;
	logic wait_s1;
	logic wait_s2;
	logic hold_s1;
	logic hold_s2;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// chip-select area from the top address bits
	function automatic logic [1:0] area_of(input logic [23:0] a);
		logic [2:0] t;
		t = a[ebi_pkg::AREA_MSB:ebi_pkg::AREA_LSB];
		if (t[2])
			area_of = 2'h3; // upper 8 MB
		else if (t[1])
			area_of = 2'h2; // 4 MB
		else
			area_of = {1'b0, t[0]}; // two 2 MB blocks
	endfunction

	// program memory region covers the lowest megabyte
	function automatic logic is_rom(input ebi_pkg::ebi_req_t r);
		is_rom = (r.space == ebi_pkg::SP_ROM) ||
			((r.space == ebi_pkg::SP_EXT) &&
			(r.addr <= ebi_pkg::INT_ROM_TOP));
	endfunction

	// internal latency in basic clocks, less one
	function automatic logic [1:0] int_lat(input ebi_pkg::ebi_req_t r);
		logic rom;
		logic [1:0] n;
		rom = is_rom(r);
		case (r.kind)
			ebi_pkg::AK_FETCH_SEQ:
				n = rom ? ebi_pkg::ROM_SEQ_CLK : ebi_pkg::RAM_SEQ_CLK;
			ebi_pkg::AK_FETCH_BRANCH:
				n = rom ? ebi_pkg::ROM_BRANCH_CLK : ebi_pkg::RAM_BRANCH_CLK;
			default:
				n = rom ? ebi_pkg::ROM_OPERAND_CLK : ebi_pkg::RAM_OPERAND_CLK;
		endcase
		// a fetch that meets a data access waits one more
		if (r.conflict && (r.kind != ebi_pkg::AK_OPERAND))
			int_lat = n;
		else
			int_lat = n - 2'h1;
	endfunction

	function automatic logic [2:0] size_bytes(input ebi_pkg::ebi_size_t s);
		case (s)
			ebi_pkg::SZ_BYTE: size_bytes = 3'h1;
			ebi_pkg::SZ_HALF: size_bytes = 3'h2;
			default: size_bytes = 3'h4;
		endcase
	endfunction

	// ------------------------------------------------------------
	// current piece
	// ------------------------------------------------------------
	logic [23:0] paddr;
	logic [1:0] parea;
	logic pwide;
	logic ptwo;
	logic phi;
	logic [15:0] pdata;
	logic [1:0] pwr;
	logic [2:0] plen;

	// peripherals always see a 16-bit bus
	always_comb begin
		paddr = cur.addr + {22'h0, boff};
		parea = area_of(paddr);
		pwide = periph | width_cfg[{parea, 1'b0}];
		plen = ptwo ? 3'h2 : 3'h1;
	end

	// pieces walk upward from the lowest byte
	ebi_piece u_piece (
		.a0_i(paddr[0]),
		.rem_i(rem),
		.boff_i(boff),
		.wide_i(pwide),
		.wdata_i(cur.wdata),
		.two_o(ptwo),
		.hi_o(phi),
		.data_o(pdata),
		.wr_mask_o(pwr)
	);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// two flops on every pin input before anything looks at it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			din_s1 <= 16'h0000;
			din_s2 <= 16'h0000;
			wait_s1 <= 1'b1;
			wait_s2 <= 1'b1;
			hold_s1 <= 1'b1;
			hold_s2 <= 1'b1;
		end else begin
			din_s1 <= shared_addr_data_lines_i;
			din_s2 <= din_s1;
			wait_s1 <= ext_wait_n_i;
			wait_s2 <= wait_s1;
			hold_s1 <= bus_hold_request_n_i;
			hold_s2 <= hold_s1;
		end
	end

	// ------------------------------------------------------------
	// basic clock
	// ------------------------------------------------------------
	// the bus runs at half the core clock; states move when ph is high
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ph <= 1'b0;
			system_clock_output_o <= 1'b0;
		end else begin
			ph <= ~ph;
			system_clock_output_o <= ph;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// mode bit resets to multiplexed; the no-op after a write is
	// software's job, the bit takes effect from the next clock, even mid-access
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sep_mode <= ebi_pkg::MODE_RST[ebi_pkg::MODE_SEP_BIT];
			width_cfg <= ebi_pkg::WIDTH_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ebi_pkg::REG_MODE_OFS)
				sep_mode <= reg_wdata_i[ebi_pkg::MODE_SEP_BIT];
			if (reg_addr_i == ebi_pkg::REG_WIDTH_OFS)
				width_cfg <= reg_wdata_i;
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ebi_pkg::REG_MODE_OFS:
					reg_rdata_o <= {15'h0000, sep_mode};
				ebi_pkg::REG_WIDTH_OFS:
					reg_rdata_o <= width_cfg;
				ebi_pkg::REG_STATUS_OFS:
					reg_rdata_o <= {12'h000, parea,
						~bus_hold_acknowledge_n_o,
						state != ST_IDLE};
				default:
					reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	// mux: T1, T2, TW*, LAST = 3+n; separate: T1, TW*, LAST = 2+n
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			cur <= '0;
			boff <= 2'h0;
			rem <= 3'h0;
			lat <= 2'h0;
			int_rom <= 1'b0;
			periph <= 1'b0;
		end else if (ph) begin
			case (state)
				ST_IDLE: begin
					if (cpu_valid_i && cpu_ready_o) begin
						cur <= cpu_req_i;
						boff <= 2'h0;
						rem <= size_bytes(cpu_req_i.size);
						lat <= int_lat(cpu_req_i);
						int_rom <= is_rom(cpu_req_i);
						periph <= cpu_req_i.space == ebi_pkg::SP_PERIPH;
						// program-memory writes go out on the pins
						if (cpu_req_i.space == ebi_pkg::SP_RAM ||
							(is_rom(cpu_req_i) && !cpu_req_i.write))
							state <= ST_INT;
						else
							state <= ST_T1;
					end else if (!hold_s2) begin
						state <= ST_HOLD;
					end
				end
				ST_T1: begin
					if (!sep_mode)
						state <= ST_T2;
					else if (!wait_s2 && !periph)
						state <= ST_TW;
					else
						state <= ST_LAST;
				end
				ST_T2: begin
					state <= (!wait_s2 && !periph) ? ST_TW : ST_LAST;
				end
				ST_TW: begin
					// waits go on while the pin stays low
					if (wait_s2)
						state <= ST_LAST;
				end
				ST_LAST: begin
					boff <= boff + plen[1:0];
					rem <= rem - plen;
					state <= (rem == plen) ? ST_IDLE : ST_T1;
				end
				ST_INT: begin
					lat <= lat - 2'h1;
					if (lat == 2'h0)
						state <= ST_IDLE;
				end
				ST_HOLD: begin
					if (hold_s2)
						state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// cpu answer
	// ------------------------------------------------------------
	// ready only in the half where a request can be taken
	always_ff @(posedge clk_i) begin
		if (srst_i)
			cpu_ready_o <= 1'b0;
		else
			cpu_ready_o <= (state == ST_IDLE) && !ph && hold_s2;
	end

	// done pulses for one core clock at the end of the access
	always_ff @(posedge clk_i) begin
		if (srst_i)
			cpu_done_o <= 1'b0;
		else
			cpu_done_o <= ph && (((state == ST_LAST) && (rem == plen)) ||
				((state == ST_INT) && (lat == 2'h0)));
	end

	// read bytes land at their offset, lower address first; the word is
	// merged combinationally so the last piece reaches the answer too,
	// and a first piece starts from zero so no stale bytes leak out
	logic [31:0] next_rbuf;
	always_comb begin
		next_rbuf = (boff == 2'h0) ? 32'h0000_0000 : rbuf;
		for (int i = 0; i < 4; i++) begin
			if (2'(i) == boff)
				next_rbuf[i*8 +: 8] = phi ? din_s2[15:8] : din_s2[7:0];
			else if (ptwo && (2'(i) == boff + 2'h1))
				next_rbuf[i*8 +: 8] = din_s2[15:8];
		end
	end

	// partial word kept between pieces
	always_ff @(posedge clk_i) begin
		if (srst_i)
			rbuf <= 32'h0000_0000;
		else if (ph && (state == ST_LAST) && !cur.write)
			rbuf <= next_rbuf;
	end

	// internal reads have no data path here; they answer zero
	always_ff @(posedge clk_i) begin
		if (srst_i)
			cpu_rdata_o <= 32'h0000_0000;
		else if (ph && (state == ST_LAST) && (rem == plen))
			cpu_rdata_o <= cur.write ? 32'h0000_0000 : next_rbuf;
		else if (ph && (state == ST_INT) && (lat == 2'h0))
			cpu_rdata_o <= 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	logic ext_cyc;
	logic strobe_on;

	// peripheral and internal cycles never reach the pins
	always_comb begin
		ext_cyc = !periph && (state == ST_T1 || state == ST_T2 ||
			state == ST_TW || state == ST_LAST);
		strobe_on = ext_cyc && (sep_mode || state != ST_T1);
	end

	// pins are registered from the state, so they trail it by one clock
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pins_o <= '0;
			pins_o.read_strobe_n <= 1'b1;
			pins_o.byte_write_strobes_n <= 2'b11;
			pins_o.chip_select_lines_n <= 4'hF;
		end else begin
			pins_o.address_latch_strobe <= 1'b0;
			pins_o.shared_oe <= 1'b0;
			pins_o.read_strobe_n <= !(strobe_on && !cur.write);
			pins_o.byte_write_strobes_n <= 2'b11;
			pins_o.chip_select_lines_n <= 4'hF;
			if (ext_cyc) begin
				pins_o.chip_select_lines_n[parea] <= 1'b0;
				pins_o.upper_address_lines <= paddr[23:16];
				if (strobe_on && cur.write)
					pins_o.byte_write_strobes_n <= ~pwr;
				if (sep_mode) begin
					// address on its own lines, no latch strobe
					pins_o.lower_address_lines <= paddr[15:0];
					pins_o.shared_addr_data_lines <= pdata;
					pins_o.shared_oe <= cur.write;
				end else if (state == ST_T1) begin
					// address phase on the shared lines
					pins_o.shared_addr_data_lines <= paddr[15:0];
					pins_o.shared_oe <= 1'b1;
					pins_o.address_latch_strobe <= 1'b1;
				end else begin
					pins_o.shared_addr_data_lines <= pdata;
					pins_o.shared_oe <= cur.write;
				end
			end
		end
	end

	// acknowledge follows the hold state; lines float meanwhile
	always_ff @(posedge clk_i) begin
		if (srst_i)
			bus_hold_acknowledge_n_o <= 1'b1;
		else
			bus_hold_acknowledge_n_o <= state != ST_HOLD;
	end

endmodule

/* File: tb_ebi_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bench of the bus interface
// ----------------------------------------
module tb_ebi_top;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic cpu_valid_i = 1'b0;
	ebi_pkg::ebi_req_t cpu_req_i = '0;
	logic cpu_ready_o;
	logic cpu_done_o;
	logic [31:0] cpu_rdata_o;
	logic [15:0] shared_addr_data_lines_i;
	logic [15:0] mem_lines;
	logic ext_wait_n_i = 1'b1;
	logic bus_hold_request_n_i = 1'b1;
	ebi_pkg::ebi_pins_t pins_o;
	logic system_clock_output_o;
	logic bus_hold_acknowledge_n_o;
	logic sep = 1'b0;
	logic [31:0] rd;
	int n_errors = 0;
	int samples_checked = 0;
	// rom then ram, seq/branch/operand, then ram fetches in conflict
	int tsp [8] = '{1, 1, 1, 2, 2, 2, 2, 2};
	int tkd [8] = '{0, 1, 2, 0, 1, 2, 0, 1};
	int tcf [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
	int tlat [8] = '{1, 2, 3, 1, 2, 1, 2, 3};
	always #4 clk_i = ~clk_i;
	// the memory fills the wire in whenever the design floats it
	assign shared_addr_data_lines_i = pins_o.shared_oe ? pins_o.shared_addr_data_lines : mem_lines;
	ebi_top ebi_top_inst (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .cpu_valid_i, .cpu_req_i, .cpu_ready_o, .cpu_done_o, .cpu_rdata_o,
		.shared_addr_data_lines_i, .ext_wait_n_i, .bus_hold_request_n_i, .pins_o,
		.system_clock_output_o, .bus_hold_acknowledge_n_o);
	ebi_mem_model ebi_mem_model_inst (.clk_i, .sep_i(sep), .pins_i(pins_o), .lines_o(mem_lines));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// the answer stands in the cycle after the strobe, seen at the closing edge
	task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
		chk({16'h0000, reg_rdata_o}, {16'h0000, exp});
	endtask
	// one access; ek counts edges from the take to the edge that sees done
	task automatic op(input logic [23:0] a, input int sz, input logic w, input logic [31:0] d,
		input int sp, input int kd, input int cf, input int ek);
		int i = 0;
		int k = 0;
		cpu_req_i <= '{a, ebi_pkg::ebi_size_t'(sz), w, d, ebi_pkg::ebi_space_t'(sp),
			ebi_pkg::ebi_kind_t'(kd), cf[0]};
		cpu_valid_i <= 1'b1;
		do begin
			@(posedge clk_i);
			i++;
		end while (cpu_ready_o !== 1'b1 && i < 300);
		cpu_valid_i <= 1'b0;
		do begin
			@(posedge clk_i);
			k++;
		end while (cpu_done_o !== 1'b1 && k < 300);
		if (k >= 300 || i >= 300) begin
			n_errors++;
			final_report();
		end
		rd = cpu_rdata_o;
		chk(k, ek);
	endtask
	function automatic logic [7:0] m(input int a);
		return ebi_mem_model_inst.mem[a];
	endfunction
	initial begin
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		// the output clock toggles on every core edge once out of reset
		@(posedge clk_i);
		rd[0] = system_clock_output_o;
		@(posedge clk_i);
		chk(rd[0] ^ system_clock_output_o, 1'b1);
		reg_chk(ebi_pkg::REG_MODE_OFS, 16'h0000);
		reg_chk(ebi_pkg::REG_WIDTH_OFS, 16'h5555);
		reg_wr(ebi_pkg::REG_WIDTH_OFS, 16'h5554);
		reg_wr(4'hE, 16'hFFFF);
		reg_chk(4'hE, 16'h0000);
		reg_chk(ebi_pkg::REG_WIDTH_OFS, 16'h5554);
		for (int j = 0; j < 8; j++)
			op(24'h000100, 2, 0, 0, tsp[j], tkd[j], tcf[j], 2 * tlat[j] + 1);
		op(24'h000020, 0, 1, 32'h0000005A, 0, 2, 0, 7);
		chk(m(8'h20), 32'h0000005A);
		op(24'h100000, 1, 1, 32'h00001234, 0, 2, 0, 13);
		op(24'h100000, 1, 1, 32'h00001234, 3, 2, 0, 7);
		op(24'h200001, 1, 1, 32'h0000BEEF, 0, 2, 0, 13);
		op(24'h200005, 2, 1, 32'h44332211, 0, 2, 0, 19);
		op(24'h20000A, 2, 1, 32'h88776655, 0, 2, 0, 13);
		chk({m(2), m(1)}, 32'h0000BEEF);
		chk({m(8), m(7), m(6), m(5)}, 32'h44332211);
		op(24'h20000A, 2, 0, 0, 0, 2, 0, 13);
		chk(rd, 32'h88776655);
		op(24'h200005, 2, 0, 0, 0, 2, 0, 19);
		chk(rd, 32'h44332211);
		// bus handed away and back; ack follows the synchronised request
		bus_hold_request_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(bus_hold_acknowledge_n_o, 1'b0);
		bus_hold_request_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk(bus_hold_acknowledge_n_o, 1'b1);
		// last access was in the second 2 MB area; bus idle and not handed away
		reg_chk(ebi_pkg::REG_STATUS_OFS, 16'h0004);
		// second reset, then separate mode chosen before any external access
		srst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		reg_chk(ebi_pkg::REG_WIDTH_OFS, 16'h5555);
		reg_wr(ebi_pkg::REG_WIDTH_OFS, 16'h5555);
		reg_wr(ebi_pkg::REG_MODE_OFS, 16'hFFFF);
		sep <= 1'b1;
		reg_chk(ebi_pkg::REG_MODE_OFS, 16'h0001);
		op(24'h800010, 2, 1, 32'hCAFEF00D, 0, 2, 0, 9);
		op(24'h800010, 2, 0, 0, 0, 2, 0, 9);
		chk(rd, 32'hCAFEF00D);
		// wait pin low for four edges from the request: two wait states, 2+2 basic clocks
		fork
			op(24'h800020, 1, 1, 32'h0000ABCD, 0, 2, 0, 9);
			begin
				ext_wait_n_i <= 1'b0;
				repeat (4) @(posedge clk_i);
				ext_wait_n_i <= 1'b1;
			end
		join
		chk({16'h0000, m(8'h21), m(8'h20)}, 32'h0000ABCD);
		final_report();
	end
endmodule
bind ebi_top ebi_props ebi_props_inst (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .cpu_valid_i, .cpu_req_i, .cpu_ready_o, .cpu_done_o, .pins_o,
	.bus_hold_acknowledge_n_o);
